//--- core/esf_pkg.sv
package esf_pkg;
  // register offsets
  localparam logic [5:0] OFF_ERROR_FLAGS  = 6'h06;
  localparam logic [5:0] OFF_STATUS_FLAGS = 6'h07;
  localparam logic [5:0] OFF_FIFO_DATA    = 6'h09;
  localparam logic [5:0] OFF_FIFO_LEVEL   = 6'h0a;
  localparam logic [5:0] OFF_WARN_LEVEL   = 6'h0b;
  // error_flags bits
  localparam int ERR_WRITE    = 7;
  localparam int ERR_OVERHEAT = 6;
  localparam int ERR_OVERFLOW = 4;
  localparam int ERR_COLL     = 3;
  localparam int ERR_CHECKSUM = 2;
  localparam int ERR_PARITY   = 1;
  localparam int ERR_SOF      = 0;
  // status_flags bits
  localparam int ST_CSUM_ZERO = 6;
  localparam int ST_CSUM_DONE = 5;
  localparam int ST_IRQ       = 4;
  localparam int ST_TIMER     = 3;
  localparam int ST_HI        = 1;
  localparam int ST_LO        = 0;
  // fifo level register
  localparam int FLUSH_BIT = 7;
  // reset values, clear and valid masks, fifo depth
  localparam logic [7:0] ERR_RESET   = 8'h00;
  localparam logic [7:0] STAT_RESET  = 8'h21;
  localparam logic [5:0] WARN_RESET  = 6'h08;
  localparam logic [7:0] RX_CLEAR    = 8'h0f;
  localparam logic [7:0] KEEP_ON_CMD = 8'h40;
  localparam logic [7:0] ERR_VALID   = 8'hdf;
  localparam int FIFO_DEPTH = 64;
endpackage

//--- core/esf_error_status_flags.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - host fifo write in auth/turnaround sets error
// - overheat sets flag, switches antenna off
// - write into full fifo sets overflow
// - collision at 106 sets, rx start clears
// - collision flag zero above 106 kBd
// - checksum fail sets flag, rx start clears
// - parity fail sets flag, rx start clears
// - bad frame start sets flag, rx start clears
// - bad byte count in auth sets frame error
// - command start clears all but overheat
// - error register read-only, resets to 00h
// - status register read-only, resets to 21h
// - checksum zero drops busy, rises on zero
// - checksum done set after compute command
// - irq pending when enabled source requests
// - timer active when timer will decrement
// - gated mode ignores gate signal level
// - nearly full when free space within threshold
// - nearly empty when count within threshold
// - fifo writes increment, reads decrement count
// - fifo clear resets count and overflow flag
// - error request raised while any error set
module esf_error_status_flags
  import esf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic [5:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic       cmd_start_in,
  input  wire logic       auth_active_in,
  input  wire logic       rf_turnaround_in,
  input  wire logic       overheat_in,
  input  wire logic       temp_clear_in,
  input  wire logic       int_push_in,
  input  wire logic       int_pop_in,
  input  wire logic       rx_start_in,
  input  wire logic       rate_106_in,
  input  wire logic       coll_det_in,
  input  wire logic       receive_checksum_enable_in,
  input  wire logic       crc_fail_in,
  input  wire logic       parity_fail_in,
  input  wire logic       sof_bad_in,
  input  wire logic       byte_count_bad_in,
  input  wire logic       crc_busy_in,
  input  wire logic       crc_done_in,
  input  wire logic       crc_result_zero_in,
  input  wire logic       crc_cmd_start_in,
  input  wire logic       crc_cmd_active_in,
  input  wire logic [7:0] irq_req_in,
  input  wire logic [7:0] irq_en_in,
  input  wire logic       timer_run_in,
  input  wire logic [1:0] timer_gate_select_in,
  output var  logic [7:0] reg_rdata_out,
  output var  logic       error_interrupt_request_out,
  output var  logic       antenna_off_out
);

  localparam logic [6:0] DEPTH_C = 7'(DEPTH);

  // free space or fill count against the threshold
  function automatic logic at_or_below(input logic [6:0] n, input logic [5:0] t);
    at_or_below = n <= {1'b0, t};
  endfunction

  logic [7:0] err_q, err_d;
  logic [6:0] fifo_fill_count_q, fifo_fill_count_d;
  logic [5:0] fifo_warning_threshold_q;
  logic       checksum_zero_q, checksum_done_q;
  logic       irq_q, timer_active_q;
  logic       ot_s1_q, ot_s2_q;
  logic [7:0] rdata_q, rdata_d;
  logic       err_irq_q, ant_off_q;

  wire host_fifo_wr = reg_wr_in && (reg_addr_in == OFF_FIFO_DATA);
  wire host_fifo_rd = reg_rd_in && (reg_addr_in == OFF_FIFO_DATA);
  wire fifo_clear   = reg_wr_in && (reg_addr_in == OFF_FIFO_LEVEL)
                      && reg_wdata_in[FLUSH_BIT];
  wire thr_wr       = reg_wr_in && (reg_addr_in == OFF_WARN_LEVEL);
  wire fifo_full    = fifo_fill_count_q >= DEPTH_C;
  wire any_wr       = host_fifo_wr || int_push_in;
  wire any_rd       = host_fifo_rd || int_pop_in;
  wire wr_ok        = any_wr && !fifo_full;
  wire rd_ok        = any_rd && (fifo_fill_count_q != 7'h00);

  wire set_wr   = host_fifo_wr && (auth_active_in || rf_turnaround_in);
  wire set_temp = ot_s2_q;
  wire set_ovf  = any_wr && fifo_full;
  wire set_coll = coll_det_in && rate_106_in;
  wire set_crc  = receive_checksum_enable_in && crc_fail_in;
  wire set_par  = parity_fail_in;
  wire set_sof  = sof_bad_in || (auth_active_in && byte_count_bad_in);
  wire any_set  = set_wr | set_temp | set_ovf | set_coll | set_crc | set_par | set_sof;

  wire fifo_nearly_full  = at_or_below(DEPTH_C - fifo_fill_count_q,
                                       fifo_warning_threshold_q);
  wire fifo_nearly_empty = at_or_below(fifo_fill_count_q,
                                       fifo_warning_threshold_q);
  // gate level is not an input here: only the run state counts, gate selection is unused
  wire timer_active_d = timer_run_in;

  wire [7:0] status_flags = {1'b0, checksum_zero_q, checksum_done_q, irq_q,
                             timer_active_q, 1'b0, fifo_nearly_full,
                             fifo_nearly_empty};

  // clears first, then sets, then the rate-106 collision clear: an event in a clearing cycle survives
  always_comb begin
    err_d = err_q;
    if (cmd_start_in) begin
      err_d = err_d & KEEP_ON_CMD;
    end
    if (rx_start_in) begin
      err_d = err_d & ~RX_CLEAR;
    end
    if (fifo_clear) begin
      err_d[ERR_OVERFLOW] = 1'b0;
    end
    if (temp_clear_in && !ot_s2_q) begin
      err_d[ERR_OVERHEAT] = 1'b0;
    end
    if (set_wr)   err_d[ERR_WRITE]    = 1'b1;
    if (set_temp) err_d[ERR_OVERHEAT] = 1'b1;
    if (set_ovf)  err_d[ERR_OVERFLOW] = 1'b1;
    if (set_coll) err_d[ERR_COLL]     = 1'b1;
    if (set_crc)  err_d[ERR_CHECKSUM] = 1'b1;
    if (set_par)  err_d[ERR_PARITY]   = 1'b1;
    if (set_sof)  err_d[ERR_SOF]      = 1'b1;
    if (!rate_106_in) begin
      err_d[ERR_COLL] = 1'b0;
    end
    err_d = err_d & ERR_VALID;
  end

  always_comb begin
    if (fifo_clear) begin
      fifo_fill_count_d = 7'h00;
    end else begin
      fifo_fill_count_d = fifo_fill_count_q + {6'h00, wr_ok}
                          - {6'h00, rd_ok};
    end
  end

  // host writes to the flag registers decode to nothing
  always_comb begin
    unique case (reg_addr_in)
      OFF_ERROR_FLAGS:  rdata_d = err_q;
      OFF_STATUS_FLAGS: rdata_d = status_flags;
      OFF_FIFO_LEVEL:   rdata_d = {1'b0, fifo_fill_count_q};
      OFF_WARN_LEVEL:   rdata_d = {2'b00, fifo_warning_threshold_q};
      default:          rdata_d = 8'h00;
    endcase
    if (!reg_rd_in) begin
      rdata_d = 8'h00;
    end
  end

  // overheat comes from the analog sensor, so it is synchronised
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ot_s1_q <= 1'b0;
      ot_s2_q <= 1'b0;
    end else begin
      ot_s1_q <= overheat_in;
      ot_s2_q <= ot_s1_q;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      err_q                    <= ERR_RESET;
      fifo_fill_count_q        <= 7'h00;
      fifo_warning_threshold_q <= WARN_RESET;
    end else begin
      err_q             <= err_d;
      fifo_fill_count_q <= fifo_fill_count_d;
      if (thr_wr) begin
        fifo_warning_threshold_q <= reg_wdata_in[5:0];
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      checksum_zero_q <= STAT_RESET[ST_CSUM_ZERO];
      checksum_done_q <= STAT_RESET[ST_CSUM_DONE];
      irq_q           <= STAT_RESET[ST_IRQ];
      timer_active_q  <= STAT_RESET[ST_TIMER];
    end else begin
      if (crc_busy_in) begin
        checksum_zero_q <= 1'b0;
      end else if (crc_done_in) begin
        checksum_zero_q <= crc_result_zero_in;
      end
      if (crc_done_in && crc_cmd_active_in) begin
        checksum_done_q <= 1'b1;
      end else if (crc_cmd_start_in) begin
        checksum_done_q <= 1'b0;
      end
      irq_q          <= |(irq_req_in & irq_en_in);
      timer_active_q <= timer_active_d;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q   <= 8'h00;
      err_irq_q <= 1'b0;
      ant_off_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      err_irq_q <= |err_d;
      ant_off_q <= err_d[ERR_OVERHEAT];
    end
  end

  assign reg_rdata_out               = rdata_q;
  assign error_interrupt_request_out = err_irq_q;
  assign antenna_off_out             = ant_off_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_crc_busy;
    crc_busy_in;
  endsequence
  sequence s_crc_zero_end;
    !crc_busy_in && crc_done_in && crc_result_zero_in;
  endsequence
  sequence s_read_err;
    reg_rd_in && reg_addr_in == OFF_ERROR_FLAGS;
  endsequence
  sequence s_read_status;
    reg_rd_in && reg_addr_in == OFF_STATUS_FLAGS;
  endsequence
  // a host write aimed at either flag register
  sequence s_flag_reg_write;
    reg_wr_in && (reg_addr_in == OFF_ERROR_FLAGS || reg_addr_in == OFF_STATUS_FLAGS);
  endsequence
  sequence s_crc_cmd_start;
    crc_cmd_start_in && !(crc_done_in && crc_cmd_active_in);
  endsequence
  sequence s_host_fifo_pop;
    host_fifo_rd && !any_wr && !fifo_clear && fifo_fill_count_q != 7'h00;
  endsequence
  // no clearing source active, so every flag must hold
  sequence s_no_clear;
    !cmd_start_in && !rx_start_in && !fifo_clear && !temp_clear_in && rate_106_in;
  endsequence

  AST_WRITE_ERR: assert property (set_wr |=> err_q[ERR_WRITE])
    else $error("fifo write error not set");
  AST_OVERHEAT: assert property (ot_s2_q |=> err_q[ERR_OVERHEAT] && antenna_off_out)
    else $error("overheat not flagged or antenna on");
  AST_OVERFLOW: assert property (any_wr && fifo_full |=> err_q[ERR_OVERFLOW])
    else $error("overflow not flagged");
  AST_COLL_SET: assert property (coll_det_in && rate_106_in |=> err_q[ERR_COLL])
    else $error("collision not flagged");
  AST_COLL_ZERO: assert property (!rate_106_in |=> !err_q[ERR_COLL])
    else $error("collision flag set above 106");
  AST_CSUM_ERR: assert property (receive_checksum_enable_in && crc_fail_in |=> err_q[ERR_CHECKSUM])
    else $error("checksum error not flagged");
  AST_PARITY: assert property (parity_fail_in |=> err_q[ERR_PARITY])
    else $error("parity error not flagged");
  AST_SOF: assert property (auth_active_in && byte_count_bad_in |=> err_q[ERR_SOF])
    else $error("frame start error not flagged");
  AST_RX_CLEAR: assert property (rx_start_in && !any_set |=> (err_q & RX_CLEAR) == 8'h00)
    else $error("receiver start did not clear");
  AST_CMD_CLEAR: assert property (cmd_start_in && !any_set |=> (err_q & ~KEEP_ON_CMD) == 8'h00)
    else $error("command start did not clear errors");
  AST_ERR_READ: assert property (s_read_err |=> reg_rdata_out == $past(err_q))
    else $error("error register read mismatch");
  AST_CSUM_ZERO: assert property (s_crc_busy ##1 s_crc_zero_end |=> checksum_zero_q)
    else $error("checksum zero did not rise");
  AST_CSUM_DONE: assert property (crc_done_in && crc_cmd_active_in |=> checksum_done_q [*1])
    else $error("checksum done not set");
  AST_IRQ: assert property (|(irq_req_in & irq_en_in) |=> status_flags[ST_IRQ])
    else $error("irq pending missing");
  AST_FULL: assert property (fifo_fill_count_q == DEPTH_C |-> status_flags[ST_HI])
    else $error("nearly full missing at full");
  AST_EMPTY: assert property (fifo_fill_count_q == 7'h00 |-> status_flags[ST_LO])
    else $error("nearly empty missing at zero");
  AST_COUNT_UP: assert property (host_fifo_wr && !fifo_full && !any_rd && !fifo_clear
    |=> fifo_fill_count_q == $past(fifo_fill_count_q) + 7'h01)
    else $error("fill count did not increment");
  AST_FLUSH: assert property (fifo_clear && !set_ovf |=> fifo_fill_count_q == 7'h00
    && !err_q[ERR_OVERFLOW])
    else $error("fifo clear incomplete");
  AST_ERR_IRQ: assert property (error_interrupt_request_out == (err_q != 8'h00))
    else $error("error request disagrees with flags");
  AST_RESERVED: assert property (!err_q[5] && !status_flags[7] && !status_flags[2])
    else $error("reserved bit set");

  // read port: data stands one cycle, zero otherwise
  AST_STATUS_READ: assert property (s_read_status
    |=> reg_rdata_out == $past(status_flags))
    else $error("status register read mismatch");
  AST_IDLE_READ: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  AST_FLUSH_READ: assert property (reg_rd_in && reg_addr_in == OFF_FIFO_LEVEL
    |=> !reg_rdata_out[FLUSH_BIT])
    else $error("fifo clear bit reads back set");

  // error flags: sets, holds and clears
  AST_STICKY: assert property (s_no_clear
    |=> (err_q & $past(err_q)) == $past(err_q))
    else $error("error flag dropped without a clear");
  AST_WRITE_NO_SET: assert property (s_flag_reg_write ##0 !any_set
    |=> (err_q & ~$past(err_q)) == 8'h00)
    else $error("host write set an error flag");
  AST_HEAT_KEPT: assert property (cmd_start_in && err_q[ERR_OVERHEAT] && !temp_clear_in
    |=> err_q[ERR_OVERHEAT])
    else $error("command start cleared overheat");
  AST_TEMP_CLEAR: assert property (temp_clear_in && !ot_s2_q
    |=> !err_q[ERR_OVERHEAT] && !antenna_off_out)
    else $error("overheat flag not cleared");
  AST_WR_ERR_IDLE: assert property (!auth_active_in && !rf_turnaround_in
    && !err_q[ERR_WRITE] |=> !err_q[ERR_WRITE])
    else $error("fifo write error set outside window");
  AST_CSUM_OFF: assert property (!receive_checksum_enable_in && !err_q[ERR_CHECKSUM]
    |=> !err_q[ERR_CHECKSUM])
    else $error("checksum error set while check disabled");
  AST_SOF_ANY: assert property (sof_bad_in |=> err_q[ERR_SOF])
    else $error("frame start error not flagged");
  AST_ERR_IRQ_SET: assert property (parity_fail_in |=> error_interrupt_request_out)
    else $error("error request not raised");
  AST_ERR_IRQ_CLEAR: assert property (cmd_start_in && !any_set && !err_q[ERR_OVERHEAT]
    |=> !error_interrupt_request_out)
    else $error("error request stayed after clear");

  // coprocessor, irq and timer status
  AST_CSUM_BUSY: assert property (s_crc_busy |=> !checksum_zero_q)
    else $error("checksum zero high while busy");
  AST_ZERO_NONZERO: assert property (!crc_busy_in && crc_done_in && !crc_result_zero_in
    |=> !checksum_zero_q)
    else $error("checksum zero set on nonzero result");
  AST_CSUM_CLEAR: assert property (s_crc_cmd_start |=> !checksum_done_q)
    else $error("checksum done not cleared");
  AST_DONE_HOLD: assert property (checksum_done_q && !crc_cmd_start_in |=> checksum_done_q)
    else $error("checksum done dropped");
  AST_CRC_DONE_NOCMD: assert property (crc_done_in && !crc_cmd_active_in
    && !checksum_done_q |=> !checksum_done_q)
    else $error("checksum done set outside compute command");
  AST_IRQ_IDLE: assert property (!(|(irq_req_in & irq_en_in)) |=> !status_flags[ST_IRQ])
    else $error("irq pending without enabled source");
  AST_TIMER_RUN: assert property (timer_run_in |=> status_flags[ST_TIMER])
    else $error("timer active missing");
  AST_TIMER_IDLE: assert property (!timer_run_in |=> !status_flags[ST_TIMER])
    else $error("timer active while stopped");
  // run state alone decides, neither gate selection nor gate level reaches here
  AST_TIMER_GATED: assert property (timer_gate_select_in != 2'h0 && timer_run_in
    |=> status_flags[ST_TIMER])
    else $error("gated timer not shown active");

  // fifo level alerts and count
  AST_HI_EXACT: assert property (status_flags[ST_HI] ==
    ({1'b0, fifo_fill_count_q} + {2'h0, fifo_warning_threshold_q} >= {1'b0, DEPTH_C}))
    else $error("nearly full disagrees with level");
  AST_LO_ABOVE: assert property (fifo_fill_count_q > {1'b0, fifo_warning_threshold_q}
    |-> !status_flags[ST_LO])
    else $error("nearly empty above threshold");
  AST_COUNT_DOWN: assert property (s_host_fifo_pop
    |=> fifo_fill_count_q == $past(fifo_fill_count_q) - 7'h01)
    else $error("fill count did not decrement");
  AST_EMPTY_POP: assert property (any_rd && !any_wr && !fifo_clear
    && fifo_fill_count_q == 7'h00 |=> fifo_fill_count_q == 7'h00)
    else $error("read of empty fifo counted");
  AST_NO_OVERCOUNT: assert property (fifo_full && !any_rd && !fifo_clear
    |=> fifo_fill_count_q == DEPTH_C)
    else $error("write into full fifo counted");

endmodule // esf_error_status_flags
`default_nettype wire

//--- testbench/esf_host.sv
`timescale 1ns/1ps
`default_nettype none
// register-port master: one strobe per access, never both at once
module esf_host (
  input  wire logic       clock_in,
  input  wire logic [7:0] reg_rdata_in,
  output var  logic [5:0] reg_addr_out,
  output var  logic [7:0] reg_wdata_out,
  output var  logic       reg_wr_out,
  output var  logic       reg_rd_out
);
  initial begin
    reg_addr_out  = 6'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end

  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
  endtask

  task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge clock_in);
    reg_rd_out <= 1'b0;
    // data stands only in the cycle after the strobe edge
    #1 d = reg_rdata_in;
  endtask
endmodule // esf_host
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import esf_pkg::*;
  localparam logic [11:0] P_CMD = 12'h001, P_TCLR = 12'h002, P_PUSH = 12'h004, P_RX = 12'h010;
  localparam logic [11:0] P_COLL = 12'h020, P_CRCF = 12'h040, P_PAR = 12'h080, P_SOF = 12'h100;
  localparam logic [11:0] P_CNT = 12'h200, P_DONE = 12'h400, P_CCMD = 12'h800, P_POP = 12'h008;
  logic        clock_in = 1'b0;
  logic        rst_in;
  logic [11:0] pls;
  logic        auth, turn, hot, rate106, rxcen, busy, rzero, cact, trun;
  logic [7:0]  ireq, ien, rdata;
  logic [1:0]  gate;
  wire  [5:0]  addr;
  wire  [7:0]  wdata;
  wire         wr, rd, err_irq, ant_off;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #20 clock_in = ~clock_in;

  esf_host host (.clock_in(clock_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

  esf_error_status_flags #(.DEPTH(64)) dut (.clock_in(clock_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .cmd_start_in(pls[0]), .auth_active_in(auth), .rf_turnaround_in(turn),
    .overheat_in(hot), .temp_clear_in(pls[1]), .int_push_in(pls[2]), .int_pop_in(pls[3]),
    .rx_start_in(pls[4]), .rate_106_in(rate106), .coll_det_in(pls[5]),
    .receive_checksum_enable_in(rxcen), .crc_fail_in(pls[6]), .parity_fail_in(pls[7]),
    .sof_bad_in(pls[8]), .byte_count_bad_in(pls[9]), .crc_busy_in(busy),
    .crc_done_in(pls[10]), .crc_result_zero_in(rzero), .crc_cmd_start_in(pls[11]),
    .crc_cmd_active_in(cact), .irq_req_in(ireq), .irq_en_in(ien), .timer_run_in(trun),
    .timer_gate_select_in(gate), .reg_rdata_out(rdata),
    .error_interrupt_request_out(err_irq), .antenna_off_out(ant_off));

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check8($sformatf("register %h", a), exp, d & m);
  endtask

  task automatic pulse(input logic [11:0] m);
    @(posedge clock_in);
    pls <= m;
    @(posedge clock_in);
    pls <= 12'h000;
  endtask

  task automatic fill(input int n);
    repeat (n) host.write_reg(OFF_FIFO_DATA, 8'h5a);
  endtask

  task automatic t_reset;
    rd_chk(OFF_ERROR_FLAGS, 8'hff, 8'h00);
    rd_chk(OFF_STATUS_FLAGS, 8'hff, 8'h21);
    host.write_reg(OFF_ERROR_FLAGS, 8'hff);
    host.write_reg(OFF_STATUS_FLAGS, 8'hde);
    rd_chk(OFF_ERROR_FLAGS, 8'hff, 8'h00);
    rd_chk(OFF_STATUS_FLAGS, 8'hff, 8'h21);
  endtask

  task automatic t_rx;
    @(posedge clock_in);
    rate106 <= 1'b1;
    rxcen   <= 1'b1;
    pulse(P_COLL | P_CRCF | P_PAR | P_SOF);
    rd_chk(OFF_ERROR_FLAGS, 8'hff, 8'h0f);
    check8("error request", 8'h01, {7'h00, err_irq});
    pulse(P_RX);
    rd_chk(OFF_ERROR_FLAGS, 8'hff, 8'h00);
    @(posedge clock_in);
    rate106 <= 1'b0;
    rxcen   <= 1'b0;
    pulse(P_COLL | P_CRCF);
    rd_chk(OFF_ERROR_FLAGS, 8'h0c, 8'h00);
    check8("error request", 8'h00, {7'h00, err_irq});
  endtask

  task automatic t_auth_heat;
    @(posedge clock_in);
    auth <= 1'b1;
    host.write_reg(OFF_FIFO_DATA, 8'h11);
    pulse(P_CNT);
    rd_chk(OFF_ERROR_FLAGS, 8'h81, 8'h81);
    @(posedge clock_in);
    auth <= 1'b0;
    pulse(P_CMD);
    rd_chk(OFF_ERROR_FLAGS, 8'hff, 8'h00);
    @(posedge clock_in);
    turn <= 1'b1;
    host.write_reg(OFF_FIFO_DATA, 8'h22);
    @(posedge clock_in);
    turn <= 1'b0;
    hot  <= 1'b1;
    repeat (5) @(posedge clock_in);
    rd_chk(OFF_ERROR_FLAGS, 8'hc0, 8'hc0);
    check8("antenna off", 8'h01, {7'h00, ant_off});
    pulse(P_CMD);
    rd_chk(OFF_ERROR_FLAGS, 8'hff, 8'h40);
    check8("error request", 8'h01, {7'h00, err_irq});
    @(posedge clock_in);
    hot <= 1'b0;
    repeat (4) @(posedge clock_in);
    pulse(P_TCLR);
    rd_chk(OFF_ERROR_FLAGS, 8'hff, 8'h00);
    check8("antenna off", 8'h00, {7'h00, ant_off});
  endtask

  task automatic t_fifo;
    logic [7:0] d;
    host.write_reg(OFF_FIFO_LEVEL, 8'h80);
    host.write_reg(OFF_WARN_LEVEL, 8'h04);
    fill(4);
    rd_chk(OFF_STATUS_FLAGS, 8'h03, 8'h01);
    fill(1);
    rd_chk(OFF_STATUS_FLAGS, 8'h03, 8'h00);
    fill(54);
    rd_chk(OFF_STATUS_FLAGS, 8'h03, 8'h00);
    fill(1);
    rd_chk(OFF_STATUS_FLAGS, 8'h03, 8'h02);
    rd_chk(OFF_FIFO_LEVEL, 8'hff, 8'h3c);
    host.read_reg(OFF_FIFO_DATA, d);
    pulse(P_POP);
    rd_chk(OFF_FIFO_LEVEL, 8'hff, 8'h3a);
    fill(6);
    pulse(P_PUSH);
    rd_chk(OFF_ERROR_FLAGS, 8'h10, 8'h10);
    rd_chk(OFF_FIFO_LEVEL, 8'hff, 8'h40);
    host.write_reg(OFF_FIFO_LEVEL, 8'h80);
    rd_chk(OFF_FIFO_LEVEL, 8'hff, 8'h00);
    rd_chk(OFF_ERROR_FLAGS, 8'h10, 8'h00);
  endtask

  task automatic t_status;
    @(posedge clock_in);
    rzero <= 1'b1;
    pulse(P_DONE);
    rd_chk(OFF_STATUS_FLAGS, 8'h40, 8'h40);
    @(posedge clock_in);
    busy <= 1'b1;
    rd_chk(OFF_STATUS_FLAGS, 8'h40, 8'h00);
    @(posedge clock_in);
    busy <= 1'b0;
    pls  <= P_DONE;
    @(posedge clock_in);
    pls  <= 12'h000;
    rd_chk(OFF_STATUS_FLAGS, 8'h40, 8'h40);
    pulse(P_CCMD);
    rd_chk(OFF_STATUS_FLAGS, 8'h20, 8'h00);
    pulse(P_DONE);
    rd_chk(OFF_STATUS_FLAGS, 8'h20, 8'h00);
    @(posedge clock_in);
    cact <= 1'b1;
    pulse(P_DONE);
    rd_chk(OFF_STATUS_FLAGS, 8'h20, 8'h20);
    @(posedge clock_in);
    cact  <= 1'b0;
    rzero <= 1'b0;
    ireq  <= 8'h04;
    ien   <= 8'h08;
    pulse(P_DONE);
    rd_chk(OFF_STATUS_FLAGS, 8'h50, 8'h00);
    @(posedge clock_in);
    ien  <= 8'h0c;
    gate <= 2'h2;
    trun <= 1'b1;
    rd_chk(OFF_STATUS_FLAGS, 8'h18, 8'h18);
    @(posedge clock_in);
    trun <= 1'b0;
    rd_chk(OFF_STATUS_FLAGS, 8'h08, 8'h00);
  endtask

  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    rst_in = 1'b1;
    {pls, auth, turn, hot, rate106, rxcen, busy, rzero, cact, trun} = '0;
    {ireq, ien, gate} = '0;
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset;
    t_rx;
    t_auth_heat;
    t_fifo;
    t_status;
    final_report;
  end

  // run needs well under 1000 cycles; ceiling leaves margin
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      final_report;
    end
  end
endmodule // testbench
`default_nettype wire
